// *** src/clock_select.v ***
// Clock multiplier, system clock and USB clock source selection.
// Oscillators arrive as pins and are sampled by core_clk, so every derived
// clock is a level toggled on sampled edges; sources must be well below core_clk.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "clock_select_defines.vh"

module clock_select (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // Oscillator pins and status
    input wire int_osc_pin,
    input wire ext_osc_pin,
    input wire crystal_valid_pin,
    // Generated clocks
    output reg sys_clk_ff,
    output reg usb_clk_ff,
    output reg ext_periph_clk_ff,
    // Interrupt
    output wire irq
);

    function div_hit;
        input [3:0] cnt;
        input [3:0] n;
        begin
            div_hit = ((cnt % n) == (n - 4'h1));
        end
    endfunction

    function near;
        input [7:0] a;
        input [7:0] b;
        begin
            near = (a > b) ? ((a - b) <= 8'h01) : ((b - a) <= 8'h01);
        end
    endfunction

    reg [2:0] int_sync_ff;
    reg [2:0] ext_sync_ff;
    reg [1:0] xv_sync_ff;
    reg xv_prev_ff;
    reg int_half_ff;
    reg [3:0] ext_cnt_ff;
    reg [2:0] prime_ff;

    reg mul_en_ff;
    reg mul_init_ff;
    reg [1:0] mul_sel_ff;
    reg [1:0] sys_sel_ff;
    reg [2:0] usb_sel_ff;
    reg [1:0] sys_act_ff;
    reg [2:0] usb_act_ff;

    reg [7:0] meas_ff;
    reg [7:0] period_ff;
    reg [7:0] step_ff;
    reg [7:0] step_cnt_ff;
    reg [1:0] left_ff;
    reg [3:0] lock_cnt_ff;
    reg locked_ff;
    reg locked_prev_ff;
    reg mul_half_ff;

    reg [`EVT_W-1:0] evt_status_ff;
    reg [`EVT_W-1:0] evt_enable_ff;

    wire crystal_valid = xv_sync_ff[1];
    // Edges are ignored until the synchronisers hold real pin levels;
    // a pin that is high at reset release would otherwise look like an edge
    wire primed = prime_ff[2];
    wire int_edge = primed & (int_sync_ff[2] ^ int_sync_ff[1]);
    wire ext_edge = primed & (ext_sync_ff[2] ^ ext_sync_ff[1]);
    wire int_div2 = int_edge & int_half_ff;
    wire ext_div2 = ext_edge & div_hit(ext_cnt_ff, `DIV2);
    wire ext_div3 = ext_edge & div_hit(ext_cnt_ff, `DIV3);
    wire ext_div4 = ext_edge & div_hit(ext_cnt_ff, `DIV4);

    wire wr_mul = reg_wr & (reg_addr == `ADDR_MUL_CTRL);
    wire wr_sel = reg_wr & (reg_addr == `ADDR_CLK_SRC_SEL);
    // Initialize only counts when enable was already set before this write
    wire nxt_init = reg_wdata[`MUL_INIT_BIT] & reg_wdata[`MUL_EN_BIT] & mul_en_ff;
    wire mul_restart = wr_mul & nxt_init;
    wire mul_run = mul_en_ff & mul_init_ff & (mul_sel_ff != `MUL_SEL_RSVD);
    // Lock clears one cycle after disable; hide it at once so a read never
    // shows locked beside a cleared enable
    wire lock_seen = locked_ff & mul_run;

    reg mul_in_edge;
    always @* begin
        case (mul_sel_ff)
            `MUL_SEL_INT: mul_in_edge = int_edge;
            `MUL_SEL_EXT: mul_in_edge = ext_edge;
            `MUL_SEL_EXT_DIV2: mul_in_edge = ext_div2;
            default: mul_in_edge = 1'b0;
        endcase
    end

    // One edge on each input edge plus three spread across the measured gap
    wire mul_edge = mul_run & (mul_in_edge | ((left_ff != 2'h0) & (step_cnt_ff == 8'h01)));
    wire mul_div2 = mul_edge & mul_half_ff;
    wire [7:0] nxt_step = (meas_ff[7:2] == 6'h00) ? 8'h01 : {2'h0, meas_ff[7:2]};

    reg sys_edge;
    always @* begin
        case (sys_act_ff)
            `SYS_SEL_INT: sys_edge = int_edge;
            `SYS_SEL_EXT: sys_edge = ext_edge;
            `SYS_SEL_MUL_DIV2: sys_edge = mul_div2;
            default: sys_edge = 1'b0;
        endcase
    end

    reg usb_edge;
    always @* begin
        case (usb_act_ff)
            `USB_SEL_MUL: usb_edge = mul_edge;
            `USB_SEL_INT_DIV2: usb_edge = int_div2;
            `USB_SEL_EXT: usb_edge = ext_edge;
            `USB_SEL_EXT_DIV2: usb_edge = ext_div2;
            `USB_SEL_EXT_DIV3: usb_edge = ext_div3;
            `USB_SEL_EXT_DIV4: usb_edge = ext_div4;
            default: usb_edge = 1'b0;
        endcase
    end

    // Pin synchronisers and oscillator dividers
    always @(posedge core_clk) begin
        if (!rst_n) begin
            int_sync_ff <= 3'h0;
            ext_sync_ff <= 3'h0;
            xv_sync_ff <= 2'h0;
            prime_ff <= 3'h0;
            xv_prev_ff <= 1'b0;
            int_half_ff <= 1'b0;
            ext_cnt_ff <= 4'h0;
            ext_periph_clk_ff <= 1'b0;
        end else begin
            int_sync_ff <= {int_sync_ff[1:0], int_osc_pin};
            ext_sync_ff <= {ext_sync_ff[1:0], ext_osc_pin};
            xv_sync_ff <= {xv_sync_ff[0], crystal_valid_pin};
            prime_ff <= {prime_ff[1:0], 1'b1};
            xv_prev_ff <= crystal_valid;
            if (int_edge)
                int_half_ff <= ~int_half_ff;
            if (ext_edge) begin
                ext_cnt_ff <= (ext_cnt_ff == `EXT_CNT_WRAP) ? 4'h0 : ext_cnt_ff + 4'h1;
                ext_periph_clk_ff <= ~ext_periph_clk_ff;
            end
        end
    end

    // Control registers
    always @(posedge core_clk) begin
        if (!rst_n) begin
            mul_en_ff <= 1'b0;
            mul_init_ff <= 1'b0;
            mul_sel_ff <= `MUL_SEL_INT;
            sys_sel_ff <= `SYS_SEL_INT;
            usb_sel_ff <= `USB_SEL_MUL;
        end else begin
            if (wr_mul) begin
                mul_en_ff <= reg_wdata[`MUL_EN_BIT];
                mul_init_ff <= nxt_init;
                mul_sel_ff <= reg_wdata[`SEL2_HI:`SEL2_LO];
            end
            if (wr_sel) begin
                sys_sel_ff <= reg_wdata[`SEL2_HI:`SEL2_LO];
                usb_sel_ff <= reg_wdata[`USB_SEL_HI:`USB_SEL_LO];
            end
        end
    end

    // Multiplier: period measurement, edge spreading and lock detection
    always @(posedge core_clk) begin
        if (!rst_n || !mul_run || mul_restart) begin
            meas_ff <= 8'h00;
            period_ff <= 8'h00;
            step_ff <= 8'h01;
            step_cnt_ff <= 8'h01;
            left_ff <= 2'h0;
            lock_cnt_ff <= 4'h0;
            locked_ff <= 1'b0;
        end else if (mul_in_edge) begin
            meas_ff <= 8'h01;
            period_ff <= meas_ff;
            step_ff <= nxt_step;
            step_cnt_ff <= nxt_step;
            left_ff <= `MUL_EDGES_PER_IN;
            // Lock needs a run of steady input periods after initialize
            if (near(meas_ff, period_ff) && meas_ff != 8'h00) begin
                if (lock_cnt_ff == `MUL_LOCK_EDGES)
                    locked_ff <= 1'b1;
                else
                    lock_cnt_ff <= lock_cnt_ff + 4'h1;
            end else begin
                lock_cnt_ff <= 4'h0;
                locked_ff <= 1'b0;
            end
        end else begin
            if (meas_ff != `MEAS_MAX)
                meas_ff <= meas_ff + 8'h01;
            if (left_ff != 2'h0) begin
                if (step_cnt_ff == 8'h01) begin
                    left_ff <= left_ff - 2'h1;
                    step_cnt_ff <= step_ff;
                end else begin
                    step_cnt_ff <= step_cnt_ff - 8'h01;
                end
            end
        end
    end

    // Output clocks; a new source is taken only while the output is low
    always @(posedge core_clk) begin
        if (!rst_n) begin
            mul_half_ff <= 1'b0;
            sys_clk_ff <= 1'b0;
            usb_clk_ff <= 1'b0;
            sys_act_ff <= `SYS_SEL_INT;
            usb_act_ff <= `USB_SEL_MUL;
        end else begin
            if (mul_edge)
                mul_half_ff <= ~mul_half_ff;
            if (sys_edge)
                sys_clk_ff <= ~sys_clk_ff;
            if (usb_edge)
                usb_clk_ff <= ~usb_clk_ff;
            // Low phase may be stretched or shortened, the high phase never
            if (!sys_clk_ff && !sys_edge)
                sys_act_ff <= sys_sel_ff;
            if (!usb_clk_ff && !usb_edge)
                usb_act_ff <= usb_sel_ff;
        end
    end

    // Events: set wins over a clear in the same cycle
    wire [`EVT_W-1:0] evt_set = {crystal_valid & ~xv_prev_ff, ~locked_ff & locked_prev_ff,
        locked_ff & ~locked_prev_ff};
    wire [`EVT_W-1:0] evt_clr = (reg_wr && reg_addr == `ADDR_EVT_CLEAR) ? reg_wdata[`EVT_W-1:0] : 3'h0;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            locked_prev_ff <= 1'b0;
            evt_status_ff <= 3'h0;
            evt_enable_ff <= 3'h0;
        end else begin
            locked_prev_ff <= locked_ff;
            evt_status_ff <= (evt_status_ff & ~evt_clr) | evt_set;
            if (reg_wr && reg_addr == `ADDR_EVT_ENABLE)
                evt_enable_ff <= reg_wdata[`EVT_W-1:0];
        end
    end

    assign irq = |(evt_status_ff & evt_enable_ff);

    // Read data stands only in the cycle after the read strobe
    always @(posedge core_clk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata_ff <= `BYTE_ZERO;
        end else if (reg_addr == `ADDR_MUL_CTRL) begin
            reg_rdata_ff <= {mul_en_ff, mul_init_ff, lock_seen, 3'h0, mul_sel_ff};
        end else if (reg_addr == `ADDR_CLK_SRC_SEL) begin
            reg_rdata_ff <= {1'b0, usb_sel_ff, 2'h0, sys_sel_ff};
        end else if (reg_addr == `ADDR_EVT_STATUS) begin
            reg_rdata_ff <= {5'h00, evt_status_ff};
        end else if (reg_addr == `ADDR_EVT_ENABLE) begin
            reg_rdata_ff <= {5'h00, evt_enable_ff};
        end else if (reg_addr == `ADDR_CLK_STATUS) begin
            reg_rdata_ff <= {6'h00, lock_seen, crystal_valid};
        end else begin
            reg_rdata_ff <= `BYTE_ZERO;
        end
    end

endmodule

// *** shared/clock_select_defines.vh ***
// Constants for the clock multiplier and clock source selection block.
// Assumes an 8-bit register port with 8-bit addresses and data.
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

`define ADDR_CLK_SRC_SEL 8'hA9
`define ADDR_MUL_CTRL 8'hB9
`define ADDR_EVT_STATUS 8'hE0
`define ADDR_EVT_CLEAR 8'hE1
`define ADDR_EVT_ENABLE 8'hE2
`define ADDR_CLK_STATUS 8'hE3

`define BYTE_ZERO 8'h00
`define MUL_EN_BIT 7
`define MUL_INIT_BIT 6
`define MUL_LOCK_BIT 5
`define USB_SEL_HI 6
`define USB_SEL_LO 4
`define SEL2_HI 1
`define SEL2_LO 0

`define MUL_SEL_INT 2'h0
`define MUL_SEL_EXT 2'h1
`define MUL_SEL_EXT_DIV2 2'h2
`define MUL_SEL_RSVD 2'h3

`define SYS_SEL_INT 2'h0
`define SYS_SEL_EXT 2'h1
`define SYS_SEL_MUL_DIV2 2'h2

`define USB_SEL_MUL 3'h0
`define USB_SEL_INT_DIV2 3'h1
`define USB_SEL_EXT 3'h2
`define USB_SEL_EXT_DIV2 3'h3
`define USB_SEL_EXT_DIV3 3'h4
`define USB_SEL_EXT_DIV4 3'h5

`define MUL_EDGES_PER_IN 2'h3
`define MUL_LOCK_EDGES 4'hF
`define MEAS_MAX 8'hFF
`define EXT_CNT_WRAP 4'hB
`define DIV2 4'h2
`define DIV3 4'h3
`define DIV4 4'h4

`define EVT_LOCK 0
`define EVT_UNLOCK 1
`define EVT_XTAL 2
`define EVT_W 3

`endif

// *** verif/clock_select_props.sv ***
// Assertions on the clock_select ports.
// Assumes register writes take effect one cycle after the strobe.
`timescale 1ns/1ps
`include "clock_select_defines.vh"
module clock_select_props (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_ff,
    // Clocks and interrupt
    input wire ext_osc_pin,
    input wire sys_clk_ff,
    input wire usb_clk_ff,
    input wire ext_periph_clk_ff,
    input wire irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    reg rd_ff;
    reg [7:0] addr_ff;
    reg [7:0] sel_ff;
    reg [2:0] en_ff;
    reg [2:0] age_ff;
    wire rd_sel = rd_ff && addr_ff == `ADDR_CLK_SRC_SEL;
    wire rd_mul = rd_ff && addr_ff == `ADDR_MUL_CTRL;
    // Age lets a pending switch finish before a stopped source is judged
    always @(posedge core_clk) begin
        rd_ff <= reg_rd && rst_n;
        addr_ff <= reg_addr;
        if (!rst_n) begin
            sel_ff <= 8'h00;
            en_ff <= 3'h0;
            age_ff <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_CLK_SRC_SEL) begin
                sel_ff <= reg_wdata;
                age_ff <= 3'h0;
            end else if (age_ff != 3'h7) begin
                age_ff <= age_ff + 3'h1;
            end
            if (reg_wr && reg_addr == `ADDR_EVT_ENABLE) begin
                en_ff <= reg_wdata[2:0];
            end
        end
    end
    a_mul_unused: assert property (rd_mul |-> reg_rdata_ff[4:2] == 3'h0)
        else $error("multiplier unused bits not zero");
    a_sel_unused: assert property (rd_sel |-> !reg_rdata_ff[7] && reg_rdata_ff[3:2] == 2'h0)
        else $error("select unused bits not zero");
    a_lock_after_init: assert property (rd_mul && reg_rdata_ff[5] |-> reg_rdata_ff[7:6] == 2'h3)
        else $error("locked without enable and init");
    a_init_needs_en: assert property (rd_mul && reg_rdata_ff[6] |-> reg_rdata_ff[7])
        else $error("init set while disabled");
    a_irq_masked: assert property (en_ff == 3'h0 |-> !irq)
        else $error("interrupt with all events masked");
    a_sys_stops: assert property (age_ff == 3'h7 && sel_ff[1:0] == 2'h3 && !sys_clk_ff |=> !sys_clk_ff)
        else $error("system clock runs on reserved select");
    a_usb_stops: assert property (age_ff == 3'h7 && sel_ff[6:5] == 2'h3 && !usb_clk_ff |=> !usb_clk_ff)
        else $error("usb clock runs on reserved select");
    a_periph_follows: assert property ($changed(ext_osc_pin) |-> ##[1:6] $changed(ext_periph_clk_ff))
        else $error("peripheral clock missed an edge");
    c_locked: cover property (rd_mul && reg_rdata_ff[5]);
    c_irq: cover property ($rose(irq));
    c_usb_stop: cover property (age_ff == 3'h7 && sel_ff[6:5] == 2'h3);
endmodule
bind clock_select clock_select_props clock_select_props_i (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .ext_osc_pin(ext_osc_pin), .sys_clk_ff(sys_clk_ff), .usb_clk_ff(usb_clk_ff),
    .ext_periph_clk_ff(ext_periph_clk_ff), .irq(irq));

// *** verif/clock_select_bench.sv ***
// Self-checking bench for clock_select: register model, oscillators, events.
// Assumes the defines header; oscillators run far below core_clk.
`timescale 1ns/1ps
`include "clock_select_defines.vh"
module clock_select_bench;
    localparam [7:0] sel_a = `ADDR_CLK_SRC_SEL;
    localparam [7:0] mul_a = `ADDR_MUL_CTRL;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg int_osc_pin = 1'b0, ext_osc_pin = 1'b0, crystal_valid_pin = 1'b0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, got;
    reg [7:0] mdl [0:255];
    wire [7:0] reg_rdata_ff;
    wire sys_clk_ff, usb_clk_ff, ext_periph_clk_ff, irq;
    integer fail_count = 0, n_checks = 0, seed = 84, cyc = 0, i, e;
    integer int_n = 0, ext_n = 0, usb_n = 0, sys_n = 0, per_n = 0, di, de, du, ds, dp;
    clock_select clock_select_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .int_osc_pin(int_osc_pin), .ext_osc_pin(ext_osc_pin), .crystal_valid_pin(crystal_valid_pin),
        .sys_clk_ff(sys_clk_ff), .usb_clk_ff(usb_clk_ff), .ext_periph_clk_ff(ext_periph_clk_ff), .irq(irq));
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge int_osc_pin) int_n = int_n + 1;
    always @(posedge ext_osc_pin) ext_n = ext_n + 1;
    always @(posedge usb_clk_ff) usb_n = usb_n + 1;
    always @(posedge sys_clk_ff) sys_n = sys_n + 1;
    always @(posedge ext_periph_clk_ff) per_n = per_n + 1;
    // Steady periods so the multiplier can lock; ceiling well above the run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc % 8 == 7) int_osc_pin <= ~int_osc_pin;
        if (cyc % 6 == 5) ext_osc_pin <= ~ext_osc_pin;
        if (cyc == 80000) begin
            fail_count = fail_count + 1;
            wrap_up;
        end
    end
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Edge counts drift by a window boundary, so rates compare with a margin
    function [7:0] near(input integer a, input integer b, input integer tol);
        near = (a - b <= tol && b - a <= tol) ? 8'h01 : 8'h00;
    endfunction
    task wr(input [7:0] a, input [7:0] d);
        begin
            if (a == sel_a) mdl[a] = d & 8'h73;
            if (a == mul_a) mdl[a] = (d & 8'h83) | ((d[7] & d[6] & mdl[a][7]) ? 8'h40 : 8'h00);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task rd(input [7:0] a);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 got = reg_rdata_ff;
            @(posedge core_clk);
        end
    endtask
    task measure;
        begin
            repeat (40) @(posedge core_clk);
            di = int_n;
            de = ext_n;
            du = usb_n;
            ds = sys_n;
            dp = per_n;
            repeat (1200) @(posedge core_clk);
            di = int_n - di;
            de = ext_n - de;
            du = usb_n - du;
            ds = sys_n - ds;
            dp = per_n - dp;
        end
    endtask
    initial begin
        mdl[sel_a] = 8'h00;
        mdl[mul_a] = 8'h00;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(sel_a);
        check(got, 8'h00);
        rd(mul_a);
        check(got, 8'h00);
        rd(8'h55);
        check(got, 8'h00);
        for (i = 0; i < 12; i = i + 1) begin
            wr(sel_a, 8'($random(seed)));
            rd(sel_a);
            check(got, mdl[sel_a]);
            wr(mul_a, 8'($random(seed)));
            rd(mul_a);
            check(got & 8'hDF, mdl[mul_a]);
        end
        wr(mul_a, 8'h00);
        wr(mul_a, 8'hC0);
        rd(mul_a);
        check(got, mdl[mul_a]);
        wr(mul_a, 8'h00);
        wr(mul_a, {6'h00, `MUL_SEL_INT});
        wr(mul_a, 8'h80);
        repeat (201) @(posedge core_clk);
        wr(`ADDR_EVT_CLEAR, 8'h07);
        wr(mul_a, 8'hC0);
        rd(mul_a);
        check(got, 8'hC0);
        for (i = 0; i < 200 && got !== 8'hE0; i = i + 1) rd(mul_a);
        check(got, 8'hE0);
        rd(`ADDR_EVT_STATUS);
        check(got, 8'h01);
        wr(`ADDR_EVT_ENABLE, 8'h01);
        check({7'h00, irq}, 8'h01);
        wr(`ADDR_EVT_ENABLE, 8'h02);
        check({7'h00, irq}, 8'h00);
        wr(`ADDR_EVT_ENABLE, 8'h01);
        wr(`ADDR_EVT_CLEAR, 8'h01);
        check({7'h00, irq}, 8'h00);
        wr(sel_a, 8'h02); // 10 MHz USB from the multiplier, 5 MHz system clock; clock recovery sits outside
        measure;
        check(near(du, 4 * di, 5), 8'h01);
        check(near(ds, 2 * di, 3), 8'h01);
        crystal_valid_pin <= 1'b1;
        repeat (40000) @(posedge core_clk);
        rd(`ADDR_CLK_STATUS);
        check(got & 8'h01, 8'h01);
        rd(`ADDR_EVT_STATUS);
        check(got & 8'h04, 8'h04);
        for (i = 1; i < 8; i = i + 1) begin
            wr(sel_a, {1'b0, 3'(i), 2'h0, 2'(i % 2)});
            measure;
            e = (i == 1) ? di / 2 : (i < 6) ? de / (i - 1) : 0;
            check(near(du, e, 2), 8'h01);
            check(near(ds, (i % 2) ? de : di, 2), 8'h01);
            check(near(dp, de, 2), 8'h01);
        end
        wr(sel_a, 8'h03);
        measure;
        check(near(ds, 0, 1), 8'h01);
        for (i = 1; i < 3; i = i + 1) begin
            wr(mul_a, 8'h00);
            wr(mul_a, 8'(i));
            wr(mul_a, 8'h80 | 8'(i));
            repeat (201) @(posedge core_clk);
            wr(mul_a, 8'hC0 | 8'(i)); // external source has run since reset
            for (e = 0; e < 200 && got !== (8'hE0 | 8'(i)); e = e + 1) rd(mul_a);
            check(got, 8'hE0 | 8'(i));
            measure;
            check(near(du, 4 * de / i, 5), 8'h01);
        end
        wr(`ADDR_EVT_CLEAR, 8'h07);
        wr(mul_a, 8'h00);
        @(posedge core_clk);
        rd(`ADDR_EVT_STATUS);
        check(got & 8'h02, 8'h02);
        wrap_up;
    end
endmodule
